// ==== tsiu_defines.vh ====
// constants of the transmit status and interrupt unit
`ifndef TSIU_DEFINES_VH
`define TSIU_DEFINES_VH

// ****************************************
// register addresses
// ****************************************
`define TSIU_ADDR_W        9
`define TSIU_A_SYNC_CTRL   9'h18E
`define TSIU_A_STAT_A      9'h190
`define TSIU_A_STAT_HDLC   9'h191
`define TSIU_A_STAT_SYNC   9'h192
`define TSIU_A_SUMMARY     9'h19F
`define TSIU_A_MASK_A      9'h1A0
`define TSIU_A_MASK_HDLC   9'h1A1
`define TSIU_A_MASK_SYNC   9'h1A2

// ****************************************
// field positions
// ****************************************
`define TSIU_B_RESYNC      0
`define TSIU_B_AUTO_DIS    1
`define TSIU_B_SYNC_EN     2
`define TSIU_B_CRC4        3
`define TSIU_B_CLK_LOSS    0
`define TSIU_B_CLK_REST    1
`define TSIU_B_MF          2
`define TSIU_B_DENS_ALIGN  3
`define TSIU_B_SUBMF       4
`define TSIU_B_SLIP        5
`define TSIU_B_EMPTY       6
`define TSIU_B_FULL        7
`define TSIU_B_NOT_FULL    0
`define TSIU_B_LOW_WATER   1
`define TSIU_B_MSG_DONE    2
`define TSIU_B_UNDERRUN    3
`define TSIU_B_LINK_EMPTY  4
`define TSIU_B_FRAME_LOSS  0
`define TSIU_B_SEARCH_RT   1

// ****************************************
// reset values and field masks
// ****************************************
`define TSIU_RST_8         8'h00
`define TSIU_CTRL_MASK     8'h0F
`define TSIU_HDLC_MASK     8'h1F
`define TSIU_SYNC_MASK     8'h01

// ****************************************
// timing
// ****************************************
`define TSIU_LOSS_PERIODS  3
`define TSIU_CNT_W         8

`endif

// ==== tsiu_host.sv ====
// host model driving the register port
`timescale 1ns/1ps

module tsiu_host (
   // clock
   input  wire        clock,
   // register port
   output logic [8:0] reg_addr = 9'h000,
   output logic       reg_wr = 1'b0,
   output logic       reg_rd = 1'b0,
   output logic [7:0] reg_wdata = 8'h00
);
   // one-cycle strobes launched at the falling edge
   task wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   task rd(input logic [8:0] a);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
   endtask
endmodule // tsiu_host

// ==== tsiu_tx_status_interrupt_unit.v ====
// transmit status, mask and interrupt registers with synchronizer control
//
// Operation
// - synchronizer runs only while enable bit is one
// - auto resync unless disable bit is set
// - resync pulse on rising edge of trigger
// - first status register bits latch until cleared
// - latch store full on overflow drop
// - latch store empty on underflow replay
// - latch slip on repeat or drop
// - T1: latch subframe multiframe event when enabled
// - T1: bit 3 latches density violation
// - E1: bit 3 latches align frame event
// - latch multiframe event at each boundary
// - clock loss latched; loss pin follows condition
// - latch clock restored when edges return
// - unmasked clock loss drives irq pin low
// - T1: latch link register empty event
// - latch underrun; request abort automatically
// - latch message done event
// - latch low water on rising condition edge
// - latch not full on rising condition edge
// - sync register: real-time search, latched loss
// - summary bits show pending register interrupts
// - mask bit one enables, zero masks
`timescale 1ns/1ps
`include "tsiu_defines.vh"

module tsiu_tx_status_interrupt_unit #(
   parameter LOSS_PERIODS = `TSIU_LOSS_PERIODS,
   parameter SYS_PER_LINE = 8
) (
   // clock and reset
   input  wire                     clock,
   input  wire                     rstn,
   // register port
   input  wire [`TSIU_ADDR_W-1:0]  reg_addr,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   input  wire [7:0]               reg_wdata,
   output reg  [7:0]               reg_rdata,
   // mode
   input  wire                     t1_mode,
   input  wire                     subframe_mf_enable,
   // event inputs, one-cycle pulses
   input  wire                     store_drop,
   input  wire                     store_repeat,
   input  wire                     subframe_mf_tick,
   input  wire                     density_violation,
   input  wire                     align_frame_tick,
   input  wire                     multiframe_tick,
   input  wire                     link_reg_shifted,
   input  wire                     fifo_empty_no_end,
   input  wire                     message_sent,
   // levels
   input  wire                     below_low_water,
   input  wire                     fifo_has_space,
   input  wire                     frame_search_active,
   input  wire                     loss_pin_enable,
   // line clock, sampled as a pin
   input  wire                     tx_line_clock,
   // synchronizer control
   output reg                      sync_run_enable,
   output reg                      auto_realign_enable,
   output reg                      crc4_search,
   output reg                      resync_start,
   output reg                      abort_send,
   // pins
   output reg                      clock_loss_pin,
   output reg                      irq_n_pin
);

   // ****************************************
   // input synchronisers
   // ****************************************
   reg [1:0] clk_sync_r;
   reg       clk_prev_r;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         clk_sync_r <= 2'h0;
         clk_prev_r <= 1'b0;
      end else begin
         clk_sync_r <= {clk_sync_r[0], tx_line_clock};
         clk_prev_r <= clk_sync_r[1];
      end
   end
   wire line_edge = clk_sync_r[1] ^ clk_prev_r;

   // ****************************************
   // line clock monitor
   // ****************************************
   localparam integer           LOSS_PROD  = LOSS_PERIODS * SYS_PER_LINE;
   localparam [`TSIU_CNT_W-1:0] LOSS_LIMIT = LOSS_PROD[`TSIU_CNT_W-1:0];
   reg [`TSIU_CNT_W-1:0] idle_cnt_r;
   reg                   loss_r;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         idle_cnt_r <= {`TSIU_CNT_W{1'b0}};
         loss_r     <= 1'b0;
      end else if (line_edge) begin
         idle_cnt_r <= {`TSIU_CNT_W{1'b0}};
         loss_r     <= 1'b0;
      end else if (idle_cnt_r >= LOSS_LIMIT) begin
         loss_r     <= 1'b1;
      end else begin
         idle_cnt_r <= idle_cnt_r + {{(`TSIU_CNT_W-1){1'b0}}, 1'b1};
      end
   end
   wire loss_set    = (idle_cnt_r >= LOSS_LIMIT) & ~loss_r & ~line_edge;
   wire restore_set = loss_r & line_edge;

   // ****************************************
   // edge detectors on fifo levels and frame search
   // ****************************************
   reg low_prev_r;
   reg space_prev_r;
   reg search_prev_r;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         low_prev_r    <= 1'b0;
         space_prev_r  <= 1'b0;
         search_prev_r <= 1'b0;
      end else begin
         low_prev_r    <= below_low_water;
         space_prev_r  <= fifo_has_space;
         search_prev_r <= frame_search_active;
      end
   end

   // ****************************************
   // event vectors
   // ****************************************
   reg [7:0] ev_a;
   reg [7:0] ev_h;
   reg [7:0] ev_s;
   always @* begin
      ev_a = `TSIU_RST_8;
      ev_a[`TSIU_B_FULL]       = store_drop;
      ev_a[`TSIU_B_EMPTY]      = store_repeat;
      ev_a[`TSIU_B_SLIP]       = store_drop | store_repeat;
      ev_a[`TSIU_B_SUBMF]      = t1_mode & subframe_mf_enable & subframe_mf_tick;
      ev_a[`TSIU_B_DENS_ALIGN] = t1_mode ? density_violation
                                         : align_frame_tick;
      ev_a[`TSIU_B_MF]         = multiframe_tick;
      ev_a[`TSIU_B_CLK_REST]   = restore_set;
      ev_a[`TSIU_B_CLK_LOSS]   = loss_set;
      ev_h = `TSIU_RST_8;
      ev_h[`TSIU_B_LINK_EMPTY] = t1_mode & link_reg_shifted;
      ev_h[`TSIU_B_UNDERRUN]   = fifo_empty_no_end;
      ev_h[`TSIU_B_MSG_DONE]   = message_sent;
      ev_h[`TSIU_B_LOW_WATER]  = below_low_water & ~low_prev_r;
      ev_h[`TSIU_B_NOT_FULL]   = fifo_has_space & ~space_prev_r;
      ev_s = `TSIU_RST_8;
      ev_s[`TSIU_B_FRAME_LOSS] = frame_search_active & ~search_prev_r;
   end

   // ****************************************
   // register writes
   // ****************************************
   wire wr_ctrl = reg_wr & (reg_addr == `TSIU_A_SYNC_CTRL);
   wire wr_sa   = reg_wr & (reg_addr == `TSIU_A_STAT_A);
   wire wr_sh   = reg_wr & (reg_addr == `TSIU_A_STAT_HDLC);
   wire wr_ss   = reg_wr & (reg_addr == `TSIU_A_STAT_SYNC);

   reg [7:0] ctrl_r;
   reg [7:0] stat_a_r;
   reg [7:0] stat_h_r;
   reg [7:0] stat_s_r;
   reg [7:0] mask_a_r;
   reg [7:0] mask_h_r;
   reg [7:0] mask_s_r;
   reg       resync_prev_r;

   // set wins over the write-one clear
   wire [7:0] stat_a_nxt = (stat_a_r & ~({8{wr_sa}} & reg_wdata)) | ev_a;
   wire [7:0] stat_h_nxt = ((stat_h_r & ~({8{wr_sh}} & reg_wdata)) | ev_h)
                           & `TSIU_HDLC_MASK;
   wire [7:0] stat_s_nxt = ((stat_s_r & ~({8{wr_ss}} & reg_wdata)) | ev_s)
                           & `TSIU_SYNC_MASK;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_r        <= `TSIU_RST_8;
         stat_a_r      <= `TSIU_RST_8;
         stat_h_r      <= `TSIU_RST_8;
         stat_s_r      <= `TSIU_RST_8;
         mask_a_r      <= `TSIU_RST_8;
         mask_h_r      <= `TSIU_RST_8;
         mask_s_r      <= `TSIU_RST_8;
         resync_prev_r <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_r <= reg_wdata & `TSIU_CTRL_MASK;
         if (reg_wr && reg_addr == `TSIU_A_MASK_A)
            mask_a_r <= reg_wdata;
         if (reg_wr && reg_addr == `TSIU_A_MASK_HDLC)
            mask_h_r <= reg_wdata & `TSIU_HDLC_MASK;
         if (reg_wr && reg_addr == `TSIU_A_MASK_SYNC)
            mask_s_r <= reg_wdata & `TSIU_SYNC_MASK;
         stat_a_r      <= stat_a_nxt;
         stat_h_r      <= stat_h_nxt;
         stat_s_r      <= stat_s_nxt;
         resync_prev_r <= ctrl_r[`TSIU_B_RESYNC];
      end
   end

   // ****************************************
   // interrupt summary
   // ****************************************
   wire pend_a = |(stat_a_r & mask_a_r);
   wire pend_h = |(stat_h_r & mask_h_r);
   wire pend_s = |(stat_s_r & mask_s_r);
   wire [7:0] summary = {5'h00, pend_s, pend_h, pend_a};

   // ****************************************
   // outputs
   // ****************************************
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync_run_enable     <= 1'b0;
         auto_realign_enable <= 1'b1;
         crc4_search         <= 1'b0;
         resync_start        <= 1'b0;
         abort_send          <= 1'b0;
         clock_loss_pin      <= 1'b0;
         irq_n_pin           <= 1'b1;
         reg_rdata           <= `TSIU_RST_8;
      end else begin
         sync_run_enable     <= ctrl_r[`TSIU_B_SYNC_EN];
         auto_realign_enable <= ~ctrl_r[`TSIU_B_AUTO_DIS];
         crc4_search         <= ctrl_r[`TSIU_B_CRC4];
         resync_start        <= ctrl_r[`TSIU_B_RESYNC] & ~resync_prev_r;
         abort_send          <= fifo_empty_no_end;
         clock_loss_pin      <= loss_pin_enable & loss_r;
         irq_n_pin           <= ~(pend_a | pend_h | pend_s);
         if (reg_rd) begin
            case (reg_addr)
               `TSIU_A_SYNC_CTRL: reg_rdata <= ctrl_r;
               `TSIU_A_STAT_A:    reg_rdata <= stat_a_r;
               `TSIU_A_STAT_HDLC: reg_rdata <= stat_h_r;
               `TSIU_A_STAT_SYNC: reg_rdata <= stat_s_r |
                                               {6'h00, frame_search_active, 1'b0};
               `TSIU_A_SUMMARY:   reg_rdata <= summary;
               `TSIU_A_MASK_A:    reg_rdata <= mask_a_r;
               `TSIU_A_MASK_HDLC: reg_rdata <= mask_h_r;
               `TSIU_A_MASK_SYNC: reg_rdata <= mask_s_r;
               default:           reg_rdata <= `TSIU_RST_8;
            endcase
         end
      end
   end

endmodule // tsiu_tx_status_interrupt_unit

// ==== tsiu_tx_status_interrupt_unit_asserts.sv ====
// port-level checker for the transmit status and interrupt unit
`timescale 1ns/1ps
`include "tsiu_defines.vh"

module tsiu_tx_status_interrupt_unit_asserts (
   // clock and reset
   input wire       clock,
   input wire       rstn,
   // register port
   input wire [8:0] reg_addr,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // levels and events
   input wire       fifo_empty_no_end,
   input wire       frame_search_active,
   input wire       loss_pin_enable,
   // outputs
   input wire       sync_run_enable,
   input wire       auto_realign_enable,
   input wire       resync_start,
   input wire       abort_send,
   input wire       clock_loss_pin,
   input wire       irq_n_pin
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // ****************************************
   // properties
   // ****************************************
   // control register to output takes two edges
   property p_run_en;
      reg_wr && reg_addr == 9'h18E |-> ##2 sync_run_enable == $past(reg_wdata[2], 2);
   endproperty
   a_run_en: assert property (p_run_en) else $error("run enable wrong");
   property p_auto;
      reg_wr && reg_addr == 9'h18E |-> ##2 auto_realign_enable == !$past(reg_wdata[1], 2);
   endproperty
   a_auto: assert property (p_auto) else $error("auto realign wrong");
   property p_rs_src; $rose(resync_start) |-> $past(reg_wr && reg_addr == 9'h18E && reg_wdata[0]) || $past(reg_wr && reg_addr == 9'h18E && reg_wdata[0], 2); endproperty
   a_rs_src: assert property (p_rs_src) else $error("resync without trigger write");
   property p_rs_one; resync_start |=> !resync_start; endproperty
   a_rs_one: assert property (p_rs_one) else $error("resync pulse too long");
   property p_abort; fifo_empty_no_end |=> abort_send; endproperty
   a_abort: assert property (p_abort) else $error("abort not sent");
   property p_irq_sum; reg_rd && reg_addr == 9'h19F |=> (reg_rdata[2:0] != 3'h0) == !irq_n_pin; endproperty
   a_irq_sum: assert property (p_irq_sum) else $error("summary and irq differ");
   property p_loss_pin; !loss_pin_enable |=> !clock_loss_pin; endproperty
   a_loss_pin: assert property (p_loss_pin) else $error("loss pin while disabled");
   property p_search; reg_rd && reg_addr == 9'h192 |=> reg_rdata[1] == $past(frame_search_active); endproperty
   a_search: assert property (p_search) else $error("search bit not real time");
endmodule // tsiu_tx_status_interrupt_unit_asserts

bind tsiu_tx_status_interrupt_unit tsiu_tx_status_interrupt_unit_asserts chk_i (.clock, .rstn,
   .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .fifo_empty_no_end, .frame_search_active,
   .loss_pin_enable, .sync_run_enable, .auto_realign_enable, .resync_start, .abort_send,
   .clock_loss_pin, .irq_n_pin);

// ==== tsiu_tx_status_interrupt_unit_test.sv ====
// self-checking bench for the transmit status and interrupt unit
`timescale 1ns/1ps

module tsiu_tx_status_interrupt_unit_test;
   logic       clock = 1'b0, rstn = 1'b0, t1 = 1'b1, lp_en = 1'b0, lclk = 1'b0, lrun = 1'b1;
   logic [8:0] ev = 9'h000;
   logic [2:0] lvl = 3'h0;
   logic [1:0] lc = 2'h0;
   logic [7:0] r, exp_q[$];
   logic [8:0] ra [9] = '{9'h18E, 9'h190, 9'h191, 9'h192, 9'h19F, 9'h1A0, 9'h1A1, 9'h1A2, 9'h1B0};
   wire  [8:0] reg_addr;
   wire  [7:0] reg_wdata, reg_rdata;
   wire        reg_wr, reg_rd, run_en, auto_en, crc4, rs, abort, loss_pin, irq_n;
   int         mismatches = 0, n_compared = 0, cyc = 0, n_rs = 0;
   tsiu_host host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata));
   tsiu_tx_status_interrupt_unit #(.LOSS_PERIODS(3), .SYS_PER_LINE(8)) uut (.clock(clock),
      .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .t1_mode(t1), .subframe_mf_enable(1'b1), .store_drop(ev[0]),
      .store_repeat(ev[1]), .subframe_mf_tick(ev[2]), .density_violation(ev[3]),
      .align_frame_tick(ev[4]), .multiframe_tick(ev[5]), .link_reg_shifted(ev[6]),
      .fifo_empty_no_end(ev[7]), .message_sent(ev[8]), .below_low_water(lvl[0]),
      .fifo_has_space(lvl[1]), .frame_search_active(lvl[2]), .loss_pin_enable(lp_en),
      .tx_line_clock(lclk), .sync_run_enable(run_en), .auto_realign_enable(auto_en),
      .crc4_search(crc4), .resync_start(rs), .abort_send(abort), .clock_loss_pin(loss_pin),
      .irq_n_pin(irq_n));
   always #12.5 clock = ~clock;
   // line clock at one eighth of the system rate, stoppable
   always @(negedge clock) begin
      lc <= lc + 2'h1;
      if (lrun && lc == 2'h3) lclk <= ~lclk;
   end
   always @(posedge clock) begin
      cyc++;
      if (rs === 1'b1) n_rs++;
      if (cyc == 20000) begin
         mismatches++;
         test_done();
      end
   end
   // read data lands at the read edge; compare with the oldest note
   always @(posedge clock) if (reg_rd === 1'b1) begin
      #1;
      chk(reg_rdata, exp_q.pop_front());
   end
   task chk(input logic [7:0] got, input logic [7:0] e);
      n_compared++;
      if (got !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task rd(input logic [8:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask
   task waitn(input int n);
      repeat (n) @(negedge clock);
   endtask
   task ev_case(input int i, input logic [8:0] a, input logic [7:0] e);
      @(negedge clock);
      ev = 9'h001 << i;
      @(negedge clock);
      ev = 9'h000;
      rd(a, e);
      host.wr(a, 8'h00);
      rd(a, e);
      host.wr(a, e);
      rd(a, 8'h00);
      $display("event case %0d done", i);
   endtask
   task lvl_case(input int i, input logic [8:0] a, input logic [7:0] e, input logic [7:0] e2);
      @(negedge clock);
      lvl[i] = 1'b1;
      waitn(1);
      rd(a, e);
      host.wr(a, 8'hFF);
      rd(a, e2);
      lvl[i] = 1'b0;
      rd(a, 8'h00);
      $display("level case %0d done", i);
   endtask
   task test_done;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(24166));
      waitn(2);
      rstn = 1'b1;
      foreach (ra[i]) rd(ra[i], 8'h00);
      for (int i = 0; i < 3; i++) begin
         r = $urandom;
         host.wr(9'h1A0 + i, r);
         rd(9'h1A0 + i, r & (i == 0 ? 8'hFF : i == 1 ? 8'h1F : 8'h01));
         host.wr(9'h1A0 + i, 8'h00);
      end
      $display("masks done");
      ev_case(0, 9'h190, 8'hA0);
      ev_case(1, 9'h190, 8'h60);
      ev_case(2, 9'h190, 8'h10);
      ev_case(3, 9'h190, 8'h08);
      t1 = 1'b0;
      ev_case(4, 9'h190, 8'h08);
      t1 = 1'b1;
      ev_case(5, 9'h190, 8'h04);
      ev_case(6, 9'h191, 8'h10);
      ev_case(7, 9'h191, 8'h08);
      ev_case(8, 9'h191, 8'h04);
      lvl_case(0, 9'h191, 8'h02, 8'h00);
      lvl_case(1, 9'h191, 8'h01, 8'h00);
      lvl_case(2, 9'h192, 8'h03, 8'h02);
      host.wr(9'h1A0, 8'h04);
      host.wr(9'h1A2, 8'h01);
      ev[5] = 1'b1;
      lvl[2] = 1'b1;
      waitn(1);
      ev[5] = 1'b0;
      waitn(3);
      chk({7'h00, irq_n}, 8'h00);
      rd(9'h19F, 8'h05);
      host.wr(9'h190, 8'h04);
      host.wr(9'h192, 8'h01);
      lvl[2] = 1'b0;
      rd(9'h19F, 8'h00);
      waitn(3);
      chk({7'h00, irq_n}, 8'h01);
      host.wr(9'h1A0, 8'h00);
      ev_case(5, 9'h190, 8'h04);
      chk({7'h00, irq_n}, 8'h01);
      $display("interrupt test done");
      host.wr(9'h1A0, 8'h01);
      lp_en = 1'b1;
      lrun = 1'b0;
      waitn(40);
      chk({6'h00, loss_pin, irq_n}, 8'h02);
      rd(9'h190, 8'h01);
      host.wr(9'h190, 8'h01);
      waitn(3);
      rd(9'h190, 8'h00);
      chk({6'h00, loss_pin, irq_n}, 8'h03);
      lrun = 1'b1;
      waitn(12);
      rd(9'h190, 8'h02);
      chk({7'h00, loss_pin}, 8'h00);
      host.wr(9'h190, 8'h02);
      $display("clock loss test done");
      host.wr(9'h18E, 8'h07);
      waitn(1);
      chk({6'h00, run_en, auto_en}, 8'h02);
      rd(9'h18E, 8'h07);
      host.wr(9'h18E, 8'h05);
      host.wr(9'h18E, 8'h04);
      host.wr(9'h18E, 8'h0D);
      waitn(1);
      chk({7'h00, crc4}, 8'h01);
      host.wr(9'h18E, 8'h00);
      waitn(3);
      chk({6'h00, run_en, auto_en}, 8'h01);
      chk(n_rs[7:0], 8'h02);
      $display("control test done");
      test_done();
   end
endmodule // tsiu_tx_status_interrupt_unit_test
